//--- rtl/dss_pkg.sv
// Operation
// - differential is first sensor minus second sensor, never reversed
// - average primary without failover alarms the loop on any sensor failure
// - failover with average primary drops a lone failed sensor
// - failover with average primary alarms and reports a double failure
// - failover with average primary keeps loop quiet on one failure, flags it
// - first-good carries first sensor while healthy, second once first fails
// - first-good stays on second until master reset or hold-off disabled
// - first-good primary without failover or hold-off alarms on any failure; digital value stays correct
// - first-good primary with hold-off alarms only when both sensors fail
// - failover enabled and first sensor failing moves primary to second
// - failover entry keeps loop quiet, flags first failure, shows it locally
// - in failover a second-sensor failure keeps loop driven and is flagged
// - failover holds second sensor while it works until a ctrl write, master reset or power-down
// - with failover on, either sensor may still feed the other three slots
// - slots 1..3, and slot 0 with failover off, select any sensor variable, terminal, or unused
`default_nettype none
package dss_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MAP = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PV = 8'h10;
  localparam logic [7:0] OFF_SV = 8'h14;
  localparam logic [7:0] OFF_TV = 8'h18;
  localparam logic [7:0] OFF_QV = 8'h1C;
  // control fields
  localparam int CTRL_FAILOVER_BIT = 0;
  localparam int CTRL_HOLDOFF_BIT = 1;
  localparam int CTRL_FOSEL_LSB = 4;
  localparam logic [1:0] FO_SEL_AVG = 2'h1;
  localparam logic [1:0] FO_SEL_FGOOD = 2'h2;
  localparam int CMD_MRESET_BIT = 0;
  // map fields: slot n at bit 4*n, three bits wide
  localparam int MAP_FIELD_STRIDE = 4;
  // status fields
  localparam int STAT_S1FAIL_BIT = 0;
  localparam int STAT_S2FAIL_BIT = 1;
  localparam int STAT_FOACT_BIT = 2;
  localparam int STAT_FGSEC_BIT = 3;
  localparam int STAT_ALARM_BIT = 4;
  // reset values
  localparam logic [1:0] CTRL_FOSEL_RESET = 2'h2;
  localparam logic [15:0] MAP_RESET = 16'h3210;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  typedef enum logic [2:0] {
    VAR_S1, VAR_S2, VAR_DIFF, VAR_AVG, VAR_FGOOD, VAR_TERM, VAR_NONE
  } dss_var_type;

  // wraps on overflow; readings are expected well inside range
  function automatic logic signed [15:0] dss_diff_of(
    input logic signed [15:0] a,
    input logic signed [15:0] b);
    logic signed [16:0] wide;
    wide = 17'(a) - 17'(b);
    return wide[15:0];
  endfunction : dss_diff_of

  // full-width sum first so the halving cannot overflow
  function automatic logic signed [15:0] dss_avg_of(
    input logic signed [15:0] a,
    input logic signed [15:0] b);
    logic signed [16:0] wide;
    wide = 17'(a) + 17'(b);
    return wide[16:1];
  endfunction : dss_avg_of
endpackage : dss_pkg
`default_nettype wire

//--- rtl/dss_var_mux.sv
`default_nettype none
// one output slot: picks a device variable by its selector code
module dss_var_mux (
  input wire logic [2:0] sel,
  input wire logic signed [15:0] firstValue,
  input wire logic signed [15:0] secondValue,
  input wire logic signed [15:0] diffValue,
  input wire logic signed [15:0] avgValue,
  input wire logic signed [15:0] firstGoodValue,
  input wire logic signed [15:0] terminalValue,
  output logic signed [15:0] value
);
  // unused and illegal codes read as zero
  always_comb begin
    case (sel)
      dss_pkg::VAR_S1: value = firstValue;
      dss_pkg::VAR_S2: value = secondValue;
      dss_pkg::VAR_DIFF: value = diffValue;
      dss_pkg::VAR_AVG: value = avgValue;
      dss_pkg::VAR_FGOOD: value = firstGoodValue;
      dss_pkg::VAR_TERM: value = terminalValue;
      default: value = dss_pkg::VALUE_RESET;
    endcase
  end
endmodule : dss_var_mux
`default_nettype wire

//--- rtl/dss_fail_tracker.sv
`default_nettype none
// sticky failover and first-good state; a set always beats a clear
module dss_fail_tracker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic measUpdate,
  input wire logic firstFailed,
  input wire logic failoverEnable,
  input wire logic holdOffOtherAlarms,
  input wire logic masterReset,
  input wire logic rearm,
  output logic failoverState,
  output logic firstGoodOnSecond
);
  logic setFailover;
  logic clearFailover;
  logic setFirstGood;
  logic clearFirstGood;
  logic next_failoverState;
  logic next_firstGoodOnSecond;

  // entry only on an update, so state moves with the outputs
  assign setFailover = measUpdate & failoverEnable & firstFailed;
  assign clearFailover = masterReset | rearm | ~failoverEnable;
  assign setFirstGood = measUpdate & firstFailed;
  assign clearFirstGood = masterReset | ~holdOffOtherAlarms;
  assign next_failoverState = setFailover
    | (failoverState & ~clearFailover);
  assign next_firstGoodOnSecond = setFirstGood
    | (firstGoodOnSecond & ~clearFirstGood);

  // state flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      failoverState <= 1'b0;
      firstGoodOnSecond <= 1'b0;
    end else begin
      failoverState <= next_failoverState;
      firstGoodOnSecond <= next_firstGoodOnSecond;
    end
  end
endmodule : dss_fail_tracker
`default_nettype wire

//--- rtl/dss_select_failover.sv
// The register addresses and the APB register port were decided locally.
`default_nettype none
// dual sensor selection, averaging and failover with an apb register file
module dss_select_failover (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic measUpdate,
  input wire logic signed [15:0] firstSensorReading,
  input wire logic signed [15:0] secondSensorReading,
  input wire logic signed [15:0] terminalReading,
  input wire logic firstSensorFailed,
  input wire logic secondSensorFailed,
  output logic signed [15:0] loopValue,
  output logic loopAlarm,
  output logic displayFirstFailed,
  output logic displaySecondFailed
);
  logic failoverEnable;
  logic holdOffOtherAlarms;
  logic [1:0] failoverSel;
  logic [15:0] mapReg;
  logic [31:0] readValue;
  logic signed [15:0] slotValue [4];
  logic signed [15:0] slotReg [4];
  logic statFirstFailed;
  logic statSecondFailed;
  logic failoverState;
  logic firstGoodOnSecond;
  logic next_loopAlarm;

  // apb decode; zero wait states, so pready stays high
  wire setupPhase = psel & ~penable;
  wire accessPhase = psel & penable;
  wire hitCtrl = (paddr == dss_pkg::OFF_CTRL);
  wire hitMap = (paddr == dss_pkg::OFF_MAP);
  wire hitCmd = (paddr == dss_pkg::OFF_CMD);
  wire hitStatus = (paddr == dss_pkg::OFF_STATUS);
  wire hitPv = (paddr == dss_pkg::OFF_PV);
  wire hitSv = (paddr == dss_pkg::OFF_SV);
  wire hitTv = (paddr == dss_pkg::OFF_TV);
  wire hitQv = (paddr == dss_pkg::OFF_QV);
  wire addrMapped = hitCtrl | hitMap | hitCmd | hitStatus
    | hitPv | hitSv | hitTv | hitQv;
  wire writeStrobe = accessPhase & pwrite & addrMapped;
  wire wrCtrl = writeStrobe & hitCtrl;
  wire wrMap = writeStrobe & hitMap;
  wire masterReset = writeStrobe & hitCmd & pwdata[dss_pkg::CMD_MRESET_BIT];
  // writing the enable bit set again is the re-arm of failover
  wire rearm = wrCtrl & pwdata[dss_pkg::CTRL_FAILOVER_BIT];
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~addrMapped;

  // control registers; written only at the completing access edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      failoverEnable <= 1'b0;
      holdOffOtherAlarms <= 1'b0;
      failoverSel <= dss_pkg::CTRL_FOSEL_RESET;
      mapReg <= dss_pkg::MAP_RESET;
    end else begin
      if (wrCtrl) begin
        failoverEnable <= pwdata[dss_pkg::CTRL_FAILOVER_BIT];
        holdOffOtherAlarms <= pwdata[dss_pkg::CTRL_HOLDOFF_BIT];
        failoverSel <= pwdata[dss_pkg::CTRL_FOSEL_LSB +: 2];
      end
      if (wrMap) begin
        mapReg <= pwdata[15:0];
      end
    end
  end

  // read mux; values are zero-extended, cmd reads as zero
  always_comb begin
    readValue = 32'h0000_0000;
    if (hitCtrl) begin
      readValue[dss_pkg::CTRL_FAILOVER_BIT] = failoverEnable;
      readValue[dss_pkg::CTRL_HOLDOFF_BIT] = holdOffOtherAlarms;
      readValue[dss_pkg::CTRL_FOSEL_LSB +: 2] = failoverSel;
    end else if (hitMap) begin
      readValue[15:0] = mapReg;
    end else if (hitStatus) begin
      readValue[dss_pkg::STAT_S1FAIL_BIT] = statFirstFailed;
      readValue[dss_pkg::STAT_S2FAIL_BIT] = statSecondFailed;
      readValue[dss_pkg::STAT_FOACT_BIT] = failoverState;
      readValue[dss_pkg::STAT_FGSEC_BIT] = firstGoodOnSecond;
      readValue[dss_pkg::STAT_ALARM_BIT] = loopAlarm;
    end else if (hitPv) begin
      readValue[15:0] = slotReg[0];
    end else if (hitSv) begin
      readValue[15:0] = slotReg[1];
    end else if (hitTv) begin
      readValue[15:0] = slotReg[2];
    end else if (hitQv) begin
      readValue[15:0] = slotReg[3];
    end
  end

  // read data caught in the setup cycle, held through the access
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata <= readValue;
    end
  end

  dss_fail_tracker u_tracker (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .measUpdate(measUpdate),
    .firstFailed(firstSensorFailed),
    .failoverEnable(failoverEnable),
    .holdOffOtherAlarms(holdOffOtherAlarms),
    .masterReset(masterReset),
    .rearm(rearm),
    .failoverState(failoverState),
    .firstGoodOnSecond(firstGoodOnSecond)
  );

  // derived device variables
  wire anyFailed = firstSensorFailed | secondSensorFailed;
  wire bothFailed = firstSensorFailed & secondSensorFailed;
  wire failoverActive = failoverState & failoverEnable;
  wire signed [15:0] diffValue =
    dss_pkg::dss_diff_of(firstSensorReading, secondSensorReading);
  wire signed [15:0] plainAvg =
    dss_pkg::dss_avg_of(firstSensorReading, secondSensorReading);
  // latch or a live failure both move first-good to the second sensor
  wire useSecondGood = firstGoodOnSecond | firstSensorFailed;
  // once in failover the second sensor stays in charge while it works
  wire pinSecond = failoverActive & ~secondSensorFailed;
  wire signed [15:0] firstGoodValue = (useSecondGood | pinSecond)
    ? secondSensorReading : firstSensorReading;
  wire dropFirst = failoverEnable
    & (firstSensorFailed | pinSecond) & ~secondSensorFailed;
  wire dropSecond = failoverEnable & secondSensorFailed
    & ~firstSensorFailed & ~pinSecond;
  // without failover a failed sensor still counts; the loop alarms anyway
  wire signed [15:0] avgValue = dropFirst ? secondSensorReading
    : (dropSecond ? firstSensorReading : plainAvg);
  // the host keeps failoverSel at one of the two legal codes
  wire [2:0] failoverPvSel = (failoverSel == dss_pkg::FO_SEL_AVG)
    ? 3'(dss_pkg::VAR_AVG) : 3'(dss_pkg::VAR_FGOOD);
  wire [2:0] pvSel = failoverEnable ? failoverPvSel : mapReg[2:0];
  wire [2:0] slotSel [4];
  assign slotSel[0] = pvSel;

  // four slots share one mux design; slots 1..3 follow the map alone
  for (genvar i = 0; i < 4; i++) begin : g_slot
    if (i > 0) begin : g_sel
      assign slotSel[i] =
        mapReg[i * dss_pkg::MAP_FIELD_STRIDE +: 3];
    end
    dss_var_mux u_mux (
      .sel(slotSel[i]),
      .firstValue(firstSensorReading),
      .secondValue(secondSensorReading),
      .diffValue(diffValue),
      .avgValue(avgValue),
      .firstGoodValue(firstGoodValue),
      .terminalValue(terminalReading),
      .value(slotValue[i])
    );
  end

  // loop alarm decision for the primary slot
  always_comb begin
    if (failoverEnable) begin
      next_loopAlarm = bothFailed;
    end else begin
      case (pvSel)
        dss_pkg::VAR_S1: next_loopAlarm = firstSensorFailed;
        dss_pkg::VAR_S2: next_loopAlarm = secondSensorFailed;
        dss_pkg::VAR_DIFF: next_loopAlarm = anyFailed;
        dss_pkg::VAR_AVG: next_loopAlarm = anyFailed;
        dss_pkg::VAR_FGOOD: begin
          next_loopAlarm = holdOffOtherAlarms
            ? bothFailed : anyFailed;
        end
        default: next_loopAlarm = 1'b0;
      endcase
    end
  end

  // every result moves only on a measurement update
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        slotReg[i] <= dss_pkg::VALUE_RESET;
      end
      loopAlarm <= 1'b0;
      statFirstFailed <= 1'b0;
      statSecondFailed <= 1'b0;
    end else if (measUpdate) begin
      for (int i = 0; i < 4; i++) begin
        slotReg[i] <= slotValue[i];
      end
      loopAlarm <= next_loopAlarm;
      statFirstFailed <= firstSensorFailed;
      statSecondFailed <= secondSensorFailed;
    end
  end

  // loop stage and local display see the registered results
  assign loopValue = slotReg[0];
  assign displayFirstFailed = statFirstFailed;
  assign displaySecondFailed = statSecondFailed;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_diff_order: assert property (
    measUpdate && mapReg[8 +: 3] == 3'(dss_pkg::VAR_DIFF)
    |=> slotReg[2] == 16'($past(firstSensorReading)
      - $past(secondSensorReading)))
    else $error("difference not first minus second");
  a_avg_any_alarm: assert property (
    measUpdate && !failoverEnable && pvSel == 3'(dss_pkg::VAR_AVG)
    && anyFailed |=> loopAlarm)
    else $error("average primary failed to alarm");
  a_avg_exclude: assert property (
    measUpdate && failoverEnable && failoverSel == dss_pkg::FO_SEL_AVG
    && firstSensorFailed && !secondSensorFailed
    |=> loopValue == $past(secondSensorReading))
    else $error("failed sensor kept in average");
  a_both_failed: assert property (
    measUpdate && failoverEnable && bothFailed
    |=> loopAlarm && statFirstFailed && statSecondFailed)
    else $error("double failure not alarmed and reported");
  a_single_quiet: assert property (
    measUpdate && failoverEnable
    && (firstSensorFailed ^ secondSensorFailed)
    |=> !loopAlarm && (statFirstFailed ^ statSecondFailed))
    else $error("single failure disturbed loop in failover");
  a_fgood_second: assert property (
    measUpdate && firstSensorFailed
    && pvSel == 3'(dss_pkg::VAR_FGOOD)
    |=> loopValue == $past(secondSensorReading))
    else $error("first-good did not move to second sensor");
  a_fgood_latched: assert property (
    firstGoodOnSecond && holdOffOtherAlarms && !masterReset
    |=> firstGoodOnSecond)
    else $error("first-good latch dropped early");
  a_fgood_alarm: assert property (
    measUpdate && !failoverEnable && pvSel == 3'(dss_pkg::VAR_FGOOD)
    && !holdOffOtherAlarms && anyFailed
    |=> loopAlarm && loopValue == $past(firstGoodValue))
    else $error("first-good primary alarm or value wrong");
  a_holdoff_quiet: assert property (
    measUpdate && !failoverEnable && pvSel == 3'(dss_pkg::VAR_FGOOD)
    && holdOffOtherAlarms && !bothFailed |=> !loopAlarm)
    else $error("hold-off did not suppress alarm");
  a_failover_entry: assert property (
    measUpdate && failoverEnable && firstSensorFailed
    |=> failoverState ##1 failoverState || !failoverEnable
      || $past(masterReset) || $past(rearm))
    else $error("failover not entered");
  a_no_revert: assert property (
    failoverActive && !masterReset && !rearm && !wrCtrl
    |=> failoverState)
    else $error("failover left without reset");
  a_hold_between: assert property (
    !measUpdate |=> $stable(loopValue) && $stable(loopAlarm))
    else $error("outputs changed between updates");
  a_mreset_clear: assert property (
    masterReset && !(measUpdate && firstSensorFailed)
    |=> !firstGoodOnSecond && !failoverState)
    else $error("master reset left state set");

  c_failover_entry: cover property (
    measUpdate && failoverEnable && firstSensorFailed ##1 failoverState);
  c_both_alarm: cover property (
    measUpdate && failoverEnable && bothFailed ##1 loopAlarm);
  c_holdoff_fgood: cover property (
    measUpdate && holdOffOtherAlarms && pvSel == 3'(dss_pkg::VAR_FGOOD)
    && firstSensorFailed);
  c_rearm: cover property (failoverState ##1 rearm ##1 !failoverState);
endmodule : dss_select_failover
`default_nettype wire

//--- testbench/dss_host_model.sv
`default_nettype none
// software side of the register bus, one transfer at a time
module dss_host_model (
  input wire logic ref_clk,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
  end

  // setup, then access held until ready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] addr,
    input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= addr;
    pwrite <= wr;
    pwdata <= wdata;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic write_reg(input logic [7:0] addr, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, addr, d, r, e);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [31:0] d,
    output logic e);
    xfer(1'b0, addr, 32'h00000000, d, e);
  endtask : read_reg

  // enabling failover always comes with a legal primary code
  task automatic set_failover(input logic [1:0] code, input logic holdOff);
    logic [1:0] legal;
    legal = (code == dss_pkg::FO_SEL_AVG)
      ? code : dss_pkg::FO_SEL_FGOOD;
    write_reg(dss_pkg::OFF_CTRL, {26'h0, legal, 2'h0, holdOff, 1'b1});
  endtask : set_failover
endmodule : dss_host_model
`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic refClk, resetN, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic measUpdate = 1'b0, firstFailed = 1'b0, secondFailed = 1'b0;
  logic signed [15:0] firstReading = 16'h0000, secondReading = 16'h0000;
  logic signed [15:0] termReading = 16'h0000, sa, sb, st;
  logic signed [15:0] loopValue;
  logic loopAlarm, dispFirst, dispSecond;
  int seed = 16, mismatches = 0, nCompared = 0, cycles = 0;

  dss_host_model i_host (.ref_clk(refClk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dss_select_failover i_dss_select_failover (.ref_clk(refClk),
    .reset_n(resetN), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .measUpdate(measUpdate),
    .firstSensorReading(firstReading), .secondSensorReading(secondReading),
    .terminalReading(termReading), .firstSensorFailed(firstFailed),
    .secondSensorFailed(secondFailed), .loopValue(loopValue),
    .loopAlarm(loopAlarm), .displayFirstFailed(dispFirst),
    .displaySecondFailed(dispSecond));

  initial begin
    refClk = 1'b0;
    forever #20 refClk = ~refClk;
  end

  // floor of the half sum, widened so it cannot overflow
  function automatic logic [15:0] exp_avg(input logic signed [15:0] a,
    input logic signed [15:0] b);
    logic signed [16:0] s;
    s = {a[15], a} + {b[15], b};
    return s[16:1];
  endfunction : exp_avg

  function automatic logic [15:0] exp_var(input logic [2:0] c);
    case (c)
      3'h0, 3'h4: return sa;
      3'h1: return sb;
      3'h2: return sa - sb;
      3'h3: return exp_avg(sa, sb);
      3'h5: return st;
      default: return 16'h0000;
    endcase
  endfunction : exp_var

  task automatic close_out();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    i_host.read_reg(a, d, e);
    check($sformatf("reg %h", a), exp, d);
    check("pslverr", 32'h0, {31'h0, e});
  endtask : reg_is

  // fresh random readings taken with one update strobe
  task automatic measure(input logic fa, input logic fb);
    sa = 16'($random(seed) % 1000);
    sb = 16'($random(seed) % 1000);
    st = 16'($random(seed) % 100);
    @(posedge refClk);
    measUpdate <= 1'b1;
    firstFailed <= fa;
    secondFailed <= fb;
    firstReading <= sa;
    secondReading <= sb;
    termReading <= st;
    @(posedge refClk);
    measUpdate <= 1'b0;
    @(posedge refClk);
    @(negedge refClk);
  endtask : measure

  // loop output is left unchecked in alarm; the pv register is still read back
  task automatic expect_out(input logic [15:0] pv, input logic alarm,
    input logic [4:0] status);
    check("loopAlarm", {31'h0, alarm}, {31'h0, loopAlarm});
    if (!alarm) check("loopValue", {16'h0, pv}, {16'h0, loopValue});
    check("displays", {30'h0, status[1:0]}, {30'h0, dispSecond, dispFirst});
    reg_is(dss_pkg::OFF_PV, {16'h0, pv});
    reg_is(dss_pkg::OFF_STATUS, {27'h0, status});
  endtask : expect_out

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge refClk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    logic [31:0] d;
    logic e;
    logic signed [15:0] held;
    resetN = 1'b0;
    repeat (20) @(posedge refClk);
    resetN <= 1'b1;
    reg_is(dss_pkg::OFF_CTRL, 32'h00000020);
    reg_is(dss_pkg::OFF_MAP, 32'h00003210);
    reg_is(dss_pkg::OFF_CMD, 32'h00000000);
    reg_is(dss_pkg::OFF_STATUS, 32'h00000000);
    i_host.read_reg(8'h40, d, e);
    check("unmapped", 32'h00000001, {d[30:0], e});
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      measure(1'b0, 1'b0);
      expect_out(sa, 1'b0, 5'h00);
      reg_is(dss_pkg::OFF_SV, {16'h0, sb});
      reg_is(dss_pkg::OFF_TV, {16'h0, exp_var(3'h2)});
      reg_is(dss_pkg::OFF_QV, {16'h0, exp_var(3'h3)});
    end
    held = loopValue;
    @(posedge refClk);
    firstReading <= ~sa;
    repeat (3) @(posedge refClk);
    check("hold", {16'h0, held}, {16'h0, loopValue});
    $display("test random done");
    for (int c = 0; c < 7; c++) begin
      i_host.write_reg(dss_pkg::OFF_MAP, {16'h0, 1'b0, 3'(c), 12'h210});
      measure(1'b0, 1'b0);
      reg_is(dss_pkg::OFF_QV, {16'h0, exp_var(3'(c))});
    end
    $display("test map done");
    i_host.write_reg(dss_pkg::OFF_MAP, 32'h00003213);
    measure(1'b0, 1'b1);
    expect_out(exp_avg(sa, sb), 1'b1, 5'h12);
    measure(1'b1, 1'b0);
    expect_out(exp_avg(sa, sb), 1'b1, 5'h11);
    $display("test plain average done");
    // average primary shares one process point, so failover goes on
    i_host.set_failover(dss_pkg::FO_SEL_AVG, 1'b0);
    i_host.write_reg(dss_pkg::OFF_MAP, 32'h00003100);
    measure(1'b0, 1'b1);
    expect_out(sa, 1'b0, 5'h02);
    measure(1'b1, 1'b0);
    expect_out(sb, 1'b0, 5'h05);
    measure(1'b0, 1'b0);
    expect_out(sb, 1'b0, 5'h04);
    reg_is(dss_pkg::OFF_SV, {16'h0, sa});
    reg_is(dss_pkg::OFF_TV, {16'h0, sb});
    measure(1'b1, 1'b1);
    // second sensor gone too: nothing pins the average any more
    expect_out(exp_avg(sa, sb), 1'b1, 5'h17);
    i_host.set_failover(dss_pkg::FO_SEL_AVG, 1'b0);
    measure(1'b0, 1'b0);
    expect_out(exp_avg(sa, sb), 1'b0, 5'h00);
    measure(1'b1, 1'b0);
    i_host.write_reg(dss_pkg::OFF_CMD, 32'h00000001);
    measure(1'b0, 1'b0);
    expect_out(exp_avg(sa, sb), 1'b0, 5'h00);
    $display("test failover done");
    i_host.write_reg(dss_pkg::OFF_CTRL, 32'h00000022);
    i_host.write_reg(dss_pkg::OFF_MAP, 32'h00003214);
    measure(1'b0, 1'b0);
    expect_out(sa, 1'b0, 5'h00);
    measure(1'b1, 1'b0);
    expect_out(sb, 1'b0, 5'h09);
    measure(1'b0, 1'b0);
    expect_out(sb, 1'b0, 5'h08);
    measure(1'b1, 1'b1);
    check("loopAlarm", 32'h1, {31'h0, loopAlarm});
    i_host.write_reg(dss_pkg::OFF_CMD, 32'h00000001);
    measure(1'b0, 1'b0);
    expect_out(sa, 1'b0, 5'h00);
    measure(1'b1, 1'b0);
    i_host.write_reg(dss_pkg::OFF_CTRL, 32'h00000020);
    measure(1'b0, 1'b0);
    expect_out(sa, 1'b0, 5'h00);
    measure(1'b1, 1'b0);
    expect_out(sb, 1'b1, 5'h11);
    measure(1'b0, 1'b1);
    expect_out(sa, 1'b1, 5'h12);
    $display("test first good done");
    // failover with first-good primary, then a power-down clears it
    i_host.set_failover(dss_pkg::FO_SEL_FGOOD, 1'b0);
    measure(1'b1, 1'b0);
    expect_out(sb, 1'b0, 5'h05);
    measure(1'b0, 1'b0);
    expect_out(sb, 1'b0, 5'h04);
    measure(1'b0, 1'b1);
    expect_out(sa, 1'b0, 5'h06);
    @(posedge refClk);
    resetN <= 1'b0;
    @(posedge refClk);
    resetN <= 1'b1;
    reg_is(dss_pkg::OFF_STATUS, 32'h00000000);
    reg_is(dss_pkg::OFF_CTRL, 32'h00000020);
    check("loopValue", 32'h0, {16'h0, loopValue});
    measure(1'b0, 1'b0);
    expect_out(sa, 1'b0, 5'h00);
    $display("test power down done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
